// ---- hw/uv_monitor_consts.svh ----
`ifndef UV_MONITOR_CONSTS_SVH
`define UV_MONITOR_CONSTS_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_UV_WARNING_THRESHOLD 8'h43
`define CMD_UV_FAULT_THRESHOLD   8'h44
`define CMD_UV_FAULT_ACTION      8'h45

// ****************************************
// Action byte fields
// ****************************************
`define ACT_SELECT_HI  7
`define ACT_SELECT_LO  6
`define ACT_RETRY_HI   5
`define ACT_RETRY_LO   3
`define ACT_DELAY_HI   2
`define ACT_DELAY_LO   0
`define RETRY_FOREVER  3'h7
`define RETRY_LATCH    3'h0

// ****************************************
// Reset values
// ****************************************
`define RST_UV_WARNING 16'h0000
`define RST_UV_FAULT   16'h0000
`define RST_UV_ACTION  8'h00
`define RST_THR_INDEX  5'h00

// ****************************************
// Hardware percentage grids, per mille
// ****************************************
`define PERMILLE_FULL  1000
`define WARN_MIN_PM    840
`define WARN_STEP_PM   10
`define WARN_STEPS     14
`define FAULT_MIN_PM   600
`define FAULT_STEP_PM  25
`define FAULT_STEPS    15

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 4
`define RISE_TIME_NS    1000
`define SHUT_TICKS_1    3'h1
`define SHUT_TICKS_3    3'h3
`define SHUT_TICKS_7    3'h7

`endif

// ---- hw/uv_monitor_pkg.sv ----
package uv_monitor_pkg;

	// Fault handling states, Gray along start, run, delay, restart_wait_period
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h4,
		ST_RESTART = 3'h0,
		ST_RUN     = 3'h1,
		ST_DELAY   = 3'h3,
		ST_RESTART_WAIT_PERIOD  = 3'h2,
		ST_LATCH   = 3'h6
	} uv_state_t;

	// Fault action select
	typedef enum logic [1:0] {
		ACT_IGNORE    = 2'h0,
		ACT_DELAYED   = 2'h1,
		ACT_IMMEDIATE = 2'h2,
		ACT_INVALID   = 2'h3
	} uv_action_t;

endpackage

// ---- hw/thr_quantizer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "uv_monitor_consts.svh"

// Maps a threshold word onto a percentage grid of the output command
module thr_quantizer #(
	parameter int MIN_PM  = 600,
	parameter int STEP_PM = 25,
	parameter int STEPS   = 15
) (
	// Operands
	input  wire logic [15:0] value,
	input  wire logic [15:0] vout_cmd,
	input  wire logic [4:0]  sel_idx,
	// Results
	output logic      [4:0]  idx,
	output logic             valid,
	output logic      [15:0] level
);

	logic [31:0] lvl_full;

	function automatic logic [31:0] cand_at(input int i, input logic [15:0] cmd);
		logic [31:0] pm;
		pm = 32'(MIN_PM + i * STEP_PM);
		return (32'(cmd) * pm) / 32'(`PERMILLE_FULL);
	endfunction

	// Round down to the nearest lower grid point
	always_comb begin
		idx = 5'h00;
		for (int i = 0; i < STEPS; i++) begin
			if (32'(value) >= cand_at(i, vout_cmd)) begin
				idx = 5'(i);
			end
		end
		valid = (32'(value) >= cand_at(0, vout_cmd)) &&
			(32'(value) <= cand_at(STEPS - 1, vout_cmd));
		lvl_full = cand_at(int'(sel_idx), vout_cmd);
		level = (lvl_full > 32'h0000ffff) ? 16'hffff : lvl_full[15:0];
	end

endmodule

`default_nettype wire

// ---- hw/output_undervoltage_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "uv_monitor_consts.svh"

module output_undervoltage_monitor
	import uv_monitor_pkg::*;
#(
	parameter int RISE_TIME_NS = `RISE_TIME_NS,
	parameter int RISE_CYCLES  = (RISE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// Command port
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_write,
	input  wire logic        cmd_read,
	input  wire logic [15:0] cmd_wdata,
	output var  logic [15:0] cmd_rdata,
	output var  logic        cmd_rvalid,
	// Host status clear
	input  wire logic        status_clear,
	// Converter side
	input  wire logic [15:0] vout_command,
	input  wire logic [15:0] vout_sense,
	input  wire logic        vout_abs_format,
	input  wire logic        output_on_cmd,
	input  wire logic        ramp_done,
	input  wire logic        pwm_clk_pin,
	// Status and control out
	output var  logic        status_none_above,
	output var  logic        status_word_vout,
	output var  logic        status_uv_warning,
	output var  logic        status_uv_fault,
	output var  logic        status_invalid_data,
	output var  logic        host_notify,
	output var  logic        power_stage_off
);

	localparam int RW = (RISE_CYCLES > 1) ? $clog2(RISE_CYCLES) : 1;

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] uv_warning_value_q;
	logic [15:0] uv_fault_value_q;
	logic [7:0]  uv_fault_action_q;
	logic [4:0]  warn_idx_q;
	logic [4:0]  fault_idx_q;
	logic [4:0]  warn_idx;
	logic [4:0]  fault_idx;
	logic        warn_ok;
	logic        fault_ok;
	logic [15:0] warn_level;
	logic [15:0] fault_level;
	logic        pwm_s1_q;
	logic        pwm_s2_q;
	logic        pwm_s3_q;
	logic        pwm_lvl_q;
	logic        pwm_prev_q;
	logic        pwm_tick;
	uv_state_t   state_q;
	uv_state_t   state_d;
	uv_action_t  uv_action_select;
	logic [2:0]  uv_restart_count;
	logic [2:0]  uv_delay_select;
	logic [2:0]  shut_ticks;
	logic [2:0]  restart_wait_period;
	logic [2:0]  dly_cnt_q;
	logic [RW-1:0] rise_cnt_q;
	logic        rise_end;
	logic [2:0]  rep_cnt_q;
	logic [2:0]  attempts_q;
	logic        ramp_seen_q;
	logic        monitoring;
	logic        warn_det;
	logic        fault_det;
	logic        write_bad;
	logic        give_up;
	logic        nota_d;
	logic        word_d;
	logic        warn_d;
	logic        fault_d;
	logic        inval_d;

	assign uv_action_select = uv_action_t'(uv_fault_action_q[`ACT_SELECT_HI:`ACT_SELECT_LO]);
	assign uv_restart_count = uv_fault_action_q[`ACT_RETRY_HI:`ACT_RETRY_LO];
	assign uv_delay_select  = uv_fault_action_q[`ACT_DELAY_HI:`ACT_DELAY_LO];

	// ****************************************
	// Threshold grids
	// ****************************************
	thr_quantizer #(
		.MIN_PM  (`WARN_MIN_PM),
		.STEP_PM (`WARN_STEP_PM),
		.STEPS   (`WARN_STEPS)
	) u_warn_grid (
		.value    (cmd_wdata),
		.vout_cmd (vout_command),
		.sel_idx  (warn_idx_q),
		.idx      (warn_idx),
		.valid    (warn_ok),
		.level    (warn_level)
	);

	thr_quantizer #(
		.MIN_PM  (`FAULT_MIN_PM),
		.STEP_PM (`FAULT_STEP_PM),
		.STEPS   (`FAULT_STEPS)
	) u_fault_grid (
		.value    (cmd_wdata),
		.vout_cmd (vout_command),
		.sel_idx  (fault_idx_q),
		.idx      (fault_idx),
		.valid    (fault_ok),
		.level    (fault_level)
	);

	// ****************************************
	// Command writes
	// ****************************************
	always_comb begin
		write_bad = 1'b0;
		if (cmd_write) begin
			case (cmd_code)
				`CMD_UV_WARNING_THRESHOLD: write_bad = !warn_ok;
				`CMD_UV_FAULT_THRESHOLD:   write_bad = !fault_ok;
				`CMD_UV_FAULT_ACTION: begin
					write_bad = (cmd_wdata[`ACT_SELECT_HI:`ACT_SELECT_LO] == 2'h3) ||
						(cmd_wdata[15:8] != 8'h00);
				end
				default: write_bad = 1'b0;
			endcase
		end
	end

	// Stored words change only by command, never by the output command
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			uv_warning_value_q <= `RST_UV_WARNING;
			uv_fault_value_q   <= `RST_UV_FAULT;
			uv_fault_action_q  <= `RST_UV_ACTION;
			warn_idx_q         <= `RST_THR_INDEX;
			fault_idx_q        <= `RST_THR_INDEX;
		end else if (cmd_write && !write_bad) begin
			case (cmd_code)
				`CMD_UV_WARNING_THRESHOLD: begin
					uv_warning_value_q <= cmd_wdata;
					warn_idx_q         <= warn_idx;
				end
				`CMD_UV_FAULT_THRESHOLD: begin
					uv_fault_value_q <= cmd_wdata;
					fault_idx_q      <= fault_idx;
				end
				`CMD_UV_FAULT_ACTION: uv_fault_action_q <= cmd_wdata[7:0];
				default: uv_fault_action_q <= uv_fault_action_q;
			endcase
		end
	end

	// ****************************************
	// Command reads
	// ****************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmd_rdata  <= 16'h0000;
			cmd_rvalid <= 1'b0;
		end else begin
			cmd_rvalid <= cmd_read;
			if (cmd_read) begin
				case (cmd_code)
					`CMD_UV_WARNING_THRESHOLD: cmd_rdata <= uv_warning_value_q;
					`CMD_UV_FAULT_THRESHOLD:   cmd_rdata <= uv_fault_value_q;
					`CMD_UV_FAULT_ACTION:      cmd_rdata <= {8'h00, uv_fault_action_q};
					default:                   cmd_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ****************************************
	// Switching clock synchroniser
	// ****************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pwm_s1_q   <= 1'b0;
			pwm_s2_q   <= 1'b0;
			pwm_s3_q   <= 1'b0;
			pwm_lvl_q  <= 1'b0;
			pwm_prev_q <= 1'b0;
		end else begin
			pwm_s1_q   <= pwm_clk_pin;
			pwm_s2_q   <= pwm_s1_q;
			pwm_s3_q   <= pwm_s2_q;
			pwm_prev_q <= pwm_lvl_q;
			if (pwm_s2_q == pwm_s3_q) begin
				pwm_lvl_q <= pwm_s3_q;
			end
		end
	end

	assign pwm_tick = pwm_lvl_q && !pwm_prev_q;

	// ****************************************
	// Detection and timing decode
	// ****************************************
	assign monitoring = (state_q == ST_RUN) || (state_q == ST_DELAY) ||
		((state_q == ST_RESTART) && ramp_seen_q);
	assign warn_det   = monitoring && (vout_sense < warn_level);
	assign fault_det  = monitoring && (vout_sense < fault_level);
	assign rise_end   = (32'(rise_cnt_q) == 32'(RISE_CYCLES - 1));
	assign give_up    = (uv_restart_count == `RETRY_LATCH) ||
		((uv_restart_count != `RETRY_FOREVER) && (attempts_q >= uv_restart_count));

	always_comb begin
		case (uv_delay_select)
			3'h0, 3'h1: begin
				shut_ticks          = `SHUT_TICKS_1;
				restart_wait_period = 3'h1;
			end
			3'h2: begin
				shut_ticks          = `SHUT_TICKS_3;
				restart_wait_period = 3'h2;
			end
			3'h3: begin
				shut_ticks          = `SHUT_TICKS_3;
				restart_wait_period = 3'h4;
			end
			3'h4: begin
				shut_ticks          = `SHUT_TICKS_3;
				restart_wait_period = 3'h6;
			end
			default: begin
				shut_ticks          = `SHUT_TICKS_7;
				restart_wait_period = uv_delay_select;
			end
		endcase
	end

	// ****************************************
	// Fault response machine
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (output_on_cmd) state_d = ST_RESTART;
			ST_RUN, ST_RESTART: begin
				if (fault_det && (uv_action_select == ACT_DELAYED)) begin
					state_d = ST_DELAY;
				end else if (fault_det && (uv_action_select == ACT_IMMEDIATE)) begin
					state_d = give_up ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
				end else if ((state_q == ST_RESTART) && ramp_seen_q && rise_end) begin
					state_d = ST_RUN;
				end
			end
			ST_DELAY: begin
				if (!fault_det) begin
					state_d = ST_RUN;
				end else if (pwm_tick && (dly_cnt_q + 3'h1 >= shut_ticks)) begin
					state_d = give_up ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
				end
			end
			ST_RESTART_WAIT_PERIOD: begin
				if (rise_end && (rep_cnt_q + 3'h1 >= restart_wait_period)) begin
					state_d = ST_RESTART;
				end
			end
			ST_LATCH: state_d = ST_LATCH;
			default:  state_d = ST_IDLE;
		endcase
		if (!output_on_cmd) begin
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Shutdown delay in switching clock ticks
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dly_cnt_q <= 3'h0;
		end else if (state_q != ST_DELAY) begin
			dly_cnt_q <= 3'h0;
		end else if (pwm_tick) begin
			dly_cnt_q <= dly_cnt_q + 3'h1;
		end
	end

	// Rise time base for restart_wait_period wait and start-up check
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rise_cnt_q <= '0;
			rep_cnt_q  <= 3'h0;
		end else if (state_d != state_q) begin
			rise_cnt_q <= '0;
			rep_cnt_q  <= 3'h0;
		end else if ((state_q == ST_RESTART_WAIT_PERIOD) || ((state_q == ST_RESTART) && ramp_seen_q)) begin
			rise_cnt_q <= rise_end ? '0 : rise_cnt_q + RW'(1);
			if (rise_end) begin
				rep_cnt_q <= rep_cnt_q + 3'h1;
			end
		end
	end

	// Ramp completion seen during a start
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ramp_seen_q <= 1'b0;
		end else if (state_q != ST_RESTART) begin
			ramp_seen_q <= 1'b0;
		end else if (ramp_done) begin
			ramp_seen_q <= 1'b1;
		end
	end

	// Restart attempts
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			attempts_q <= 3'h0;
		end else if ((state_d == ST_IDLE) || ((state_q == ST_RESTART) && (state_d == ST_RUN))) begin
			attempts_q <= 3'h0;
		end else if ((state_q == ST_RESTART_WAIT_PERIOD) && (state_d == ST_RESTART) && (attempts_q != 3'h7)) begin
			attempts_q <= attempts_q + 3'h1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			power_stage_off <= 1'b1;
		end else begin
			power_stage_off <= (state_d == ST_IDLE) || (state_d == ST_RESTART_WAIT_PERIOD) ||
				(state_d == ST_LATCH);
		end
	end

	// ****************************************
	// Status bits, set wins over clear
	// ****************************************
	assign warn_d  = warn_det || (status_uv_warning && !status_clear);
	assign fault_d = fault_det || (status_uv_fault && !status_clear);
	assign nota_d  = fault_det || (status_none_above && !status_clear);
	assign word_d  = warn_det || fault_det || (status_word_vout && !status_clear);
	assign inval_d = write_bad || (status_invalid_data && !status_clear);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status_uv_warning   <= 1'b0;
			status_uv_fault     <= 1'b0;
			status_none_above   <= 1'b0;
			status_word_vout    <= 1'b0;
			status_invalid_data <= 1'b0;
			host_notify         <= 1'b0;
		end else begin
			status_uv_warning   <= warn_d;
			status_uv_fault     <= fault_d;
			status_none_above   <= nota_d;
			status_word_vout    <= word_d;
			status_invalid_data <= inval_d;
			host_notify         <= warn_d || fault_d || inval_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	warn_store_a: assert property (cmd_write && !write_bad &&
		(cmd_code == `CMD_UV_WARNING_THRESHOLD) |=> uv_warning_value_q == $past(cmd_wdata))
		else $error("warning threshold not stored");
	fault_read_a: assert property (cmd_read && (cmd_code == `CMD_UV_FAULT_THRESHOLD)
		|=> cmd_rvalid && (cmd_rdata == uv_fault_value_q))
		else $error("fault threshold read wrong");
	warn_flag_a: assert property (warn_det |=> status_uv_warning &&
		status_word_vout && host_notify)
		else $error("warning not flagged");
	fault_flag_a: assert property (fault_det |=> status_uv_fault &&
		status_none_above && status_word_vout && host_notify)
		else $error("fault not flagged");
	bad_action_a: assert property (cmd_write && (cmd_code == `CMD_UV_FAULT_ACTION) &&
		(cmd_wdata[7:6] == 2'h3) |=> status_invalid_data &&
		(uv_fault_action_q == $past(uv_fault_action_q)))
		else $error("invalid action accepted");
	ignore_run_a: assert property ((state_q == ST_RUN) && output_on_cmd &&
		(uv_action_select == ACT_IGNORE) |=> state_q == ST_RUN)
		else $error("ignored fault stopped output");
	latch_off_a: assert property ((state_q == ST_RUN) && fault_det && output_on_cmd &&
		(uv_action_select == ACT_IMMEDIATE) && (uv_restart_count == 3'h0)
		|=> (state_q == ST_LATCH) && power_stage_off)
		else $error("no latch off");
	success_clear_a: assert property ((state_q == ST_RESTART) ##1 (state_q == ST_RUN)
		|-> attempts_q == 3'h0)
		else $error("attempts not cleared");
	status_hold_a: assert property (status_uv_fault && !status_clear
		|=> status_uv_fault [*1])
		else $error("fault status dropped");
	delay_bound_a: assert property ((state_q == ST_DELAY) && fault_det &&
		output_on_cmd && ((uv_delay_select < 3'h2) || (dly_cnt_q == 3'h6)) && pwm_tick
		|=> state_q != ST_DELAY)
		else $error("shutdown delay too long");

endmodule

`default_nettype wire

// ---- testbench/uv_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Host side of the command port
// ****************************************
module uv_host_model (
	// Clock
	input  wire logic        clock,
	// Command port
	output logic      [7:0]  cmd_code,
	output logic             cmd_write,
	output logic             cmd_read,
	output logic      [15:0] cmd_wdata,
	input  wire logic [15:0] cmd_rdata,
	input  wire logic        cmd_rvalid
);
	initial begin
		cmd_code = 8'h00;
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		cmd_wdata = 16'h0000;
	end

	// Word or byte write, then the data lines stop showing the old word
	task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
		@(posedge clock);
		cmd_code  <= code;
		cmd_wdata <= data;
		cmd_write <= 1'b1;
		@(posedge clock);
		cmd_write <= 1'b0;
		cmd_code  <= ~code;
		cmd_wdata <= ~data;
	endtask

	// Read, answer taken in the cycle after the request
	task automatic read_cmd(input logic [7:0] code, output logic [15:0] data, output logic valid);
		@(posedge clock);
		cmd_code <= code;
		cmd_read <= 1'b1;
		@(posedge clock);
		cmd_read <= 1'b0;
		cmd_code <= ~code;
		@(negedge clock);
		valid = cmd_rvalid;
		data  = cmd_rdata;
	endtask
endmodule

`default_nettype wire

// ---- testbench/tb_output_undervoltage_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "uv_monitor_consts.svh"

module tb_output_undervoltage_monitor
	import uv_monitor_pkg::*;
;
	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] wdata;
		logic [15:0] sense;
		logic [15:0] rdata;
		logic        inv;
		logic        fault;
		logic        warn;
	} row_t;

	localparam logic [7:0] wc = `CMD_UV_WARNING_THRESHOLD;
	localparam logic [7:0] fc = `CMD_UV_FAULT_THRESHOLD;
	localparam logic [7:0] ac = `CMD_UV_FAULT_ACTION;
	// Output command 1000, so levels read directly as per mille
	localparam row_t rows [13] = '{
		'{wc, 16'h0384, 16'h03b6, 16'h0384, 1'b0, 1'b0, 1'b0},
		'{wc, 16'h0389, 16'h0386, 16'h0389, 1'b0, 1'b0, 1'b0},
		'{wc, 16'h0389, 16'h0383, 16'h0389, 1'b0, 1'b0, 1'b1},
		'{wc, 16'h03d4, 16'h03b6, 16'h0389, 1'b1, 1'b0, 1'b0},
		'{wc, 16'h033e, 16'h03b6, 16'h0389, 1'b1, 1'b0, 1'b0},
		'{fc, 16'h0320, 16'h0325, 16'h0320, 1'b0, 1'b0, 1'b1},
		'{fc, 16'h032a, 16'h0321, 16'h032a, 1'b0, 1'b0, 1'b1},
		'{fc, 16'h032a, 16'h031f, 16'h032a, 1'b0, 1'b1, 1'b1},
		'{fc, 16'h03c0, 16'h03b6, 16'h032a, 1'b1, 1'b0, 1'b0},
		'{ac, 16'h00c0, 16'h03b6, 16'h0000, 1'b1, 1'b0, 1'b0},
		'{ac, 16'h0100, 16'h03b6, 16'h0000, 1'b1, 1'b0, 1'b0},
		'{ac, 16'h003a, 16'h03b6, 16'h003a, 1'b0, 1'b0, 1'b0},
		'{8'h46, 16'h1234, 16'h03b6, 16'h0000, 1'b0, 1'b0, 1'b0}
	};

	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] cmd_code;
	logic cmd_write, cmd_read, cmd_rvalid;
	logic [15:0] cmd_wdata, cmd_rdata;
	logic status_clear = 1'b0;
	logic [15:0] vout_command = 16'h03e8;
	logic [15:0] vout_sense = 16'h03e8;
	logic vout_abs_format = 1'b0;
	logic output_on_cmd = 1'b0;
	logic ramp_done = 1'b1;
	logic pwm_clk_pin = 1'b0;
	logic status_none_above, status_word_vout, status_uv_warning, status_uv_fault;
	logic status_invalid_data, host_notify, power_stage_off;
	int num_errors = 0;
	int samples_checked = 0;
	logic [15:0] rd;
	logic rv;
	int n;
	logic prev;

	always #2 clock = ~clock;

	uv_host_model host (
		.clock(clock), .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_read(cmd_read),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid)
	);

	output_undervoltage_monitor #(.RISE_TIME_NS(16)) uut (
		.clock(clock), .arst_n(arst_n), .cmd_code(cmd_code), .cmd_write(cmd_write),
		.cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid), .status_clear(status_clear), .vout_command(vout_command),
		.vout_sense(vout_sense), .vout_abs_format(vout_abs_format),
		.output_on_cmd(output_on_cmd), .ramp_done(ramp_done), .pwm_clk_pin(pwm_clk_pin),
		.status_none_above(status_none_above), .status_word_vout(status_word_vout),
		.status_uv_warning(status_uv_warning), .status_uv_fault(status_uv_fault),
		.status_invalid_data(status_invalid_data), .host_notify(host_notify),
		.power_stage_off(power_stage_off)
	);

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_status(input logic inv, input logic flt, input logic wrn);
		check("invalid", status_invalid_data, inv);
		check("fault", status_uv_fault, flt);
		check("none above", status_none_above, flt);
		check("warning", status_uv_warning, wrn);
		check("word vout", status_word_vout, flt | wrn);
		check("notify", host_notify, inv | flt | wrn);
	endtask

	task automatic clear_status;
		@(posedge clock);
		status_clear <= 1'b1;
		@(posedge clock);
		status_clear <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check_status(1'b0, 1'b0, 1'b0);
	endtask

	task automatic wait_off(input logic val, input int lim);
		int k;
		k = 0;
		@(negedge clock);
		while (power_stage_off !== val && k < lim) begin
			@(negedge clock);
			k++;
		end
		check("stage off", power_stage_off, val);
	endtask

	task automatic pwm_tick;
		@(posedge clock);
		pwm_clk_pin <= 1'b1;
		repeat (3) @(posedge clock);
		pwm_clk_pin <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	task automatic restart_out;
		@(posedge clock);
		vout_sense <= 16'h03e8;
		output_on_cmd <= 1'b0;
		repeat (3) @(posedge clock);
		output_on_cmd <= 1'b1;
		wait_off(1'b0, 40);
		clear_status;
	endtask

	task automatic summarize;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		summarize();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clock);
		@(negedge clock);
		check("stage off", power_stage_off, 1'b1);
		check("read data", cmd_rdata, 16'h0000);
		check_status(1'b0, 1'b0, 1'b0);
		@(posedge clock);
		arst_n <= 1'b1;
		output_on_cmd <= 1'b1;
		wait_off(1'b0, 40);
		foreach (rows[i]) begin
			host.write_cmd(rows[i].code, rows[i].wdata);
			host.read_cmd(rows[i].code, rd, rv);
			check("read valid", {15'h0000, rv}, 16'h0001);
			check("read data", rd, rows[i].rdata);
			@(posedge clock);
			vout_sense <= rows[i].sense;
			repeat (3) @(posedge clock);
			@(negedge clock);
			check_status(rows[i].inv, rows[i].fault, rows[i].warn);
			@(posedge clock);
			vout_sense <= 16'h03e8;
			repeat (3) @(posedge clock);
			@(negedge clock);
			check_status(rows[i].inv, rows[i].fault, rows[i].warn);
			clear_status;
		end
		// Stored threshold kept across a new output command
		@(posedge clock);
		vout_abs_format <= 1'b1;
		vout_command <= 16'h07d0;
		host.read_cmd(wc, rd, rv);
		check("read data", rd, 16'h0389);
		@(posedge clock);
		vout_command <= 16'h03e8;
		clear_status;
		// Immediate shutdown, no retry
		host.write_cmd(ac, 16'h0080);
		@(posedge clock);
		vout_sense <= 16'h02bc;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check("stage off", power_stage_off, 1'b1);
		@(posedge clock);
		vout_sense <= 16'h03e8;
		repeat (40) @(posedge clock);
		@(negedge clock);
		check("stage off", power_stage_off, 1'b1);
		restart_out;
		// Delayed shutdown after seven switching ticks
		host.write_cmd(ac, 16'h0045);
		@(posedge clock);
		vout_sense <= 16'h02bc;
		repeat (10) @(posedge clock);
		repeat (6) pwm_tick;
		repeat (5) @(posedge clock);
		@(negedge clock);
		check("stage off", power_stage_off, 1'b0);
		pwm_tick;
		wait_off(1'b1, 8);
		restart_out;
		// One retry after a four rise time wait, then latch
		host.write_cmd(ac, 16'h008b);
		@(posedge clock);
		vout_sense <= 16'h02bc;
		wait_off(1'b1, 4);
		n = 0;
		while (power_stage_off === 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		check("wait span", {15'h0000, n >= 15 && n <= 18}, 16'h0001);
		wait_off(1'b1, 20);
		repeat (40) @(posedge clock);
		@(negedge clock);
		check("stage off", power_stage_off, 1'b1);
		restart_out;
		// Endless retry until start-up succeeds
		host.write_cmd(ac, 16'h00b8);
		@(posedge clock);
		vout_sense <= 16'h02bc;
		n = 0;
		prev = 1'b0;
		repeat (120) begin
			@(negedge clock);
			if (prev === 1'b1 && power_stage_off === 1'b0) begin
				n++;
			end
			prev = power_stage_off;
		end
		check("restarts", {15'h0000, n > 5}, 16'h0001);
		@(posedge clock);
		vout_sense <= 16'h03e8;
		wait_off(1'b0, 40);
		repeat (20) @(posedge clock);
		@(negedge clock);
		check("stage off", power_stage_off, 1'b0);
		summarize();
	end
endmodule

`default_nettype wire
